// *** hw/amev_block.sv ***
`timescale 1ns/1ps
module amev_block
	import amev_pkg::*;
(
	input  wire logic                     clk,
	input  wire logic                     rstn,
	input  wire amev_io_req_t             io_req,
	output logic [7:0]                    io_rdata,
	input  wire logic [AMEV_NUM_SRC-1:0]  src_irq_status,
	input  wire logic [AMEV_NUM_EDGE-1:0] edge_irq_pin,
	input  wire logic                     global_release_set,
	input  wire logic                     global_event_status_clr,
	input  wire logic                     busmaster_event_status_clr,
	input  wire logic                     global_event_enable,
	input  wire logic                     busmaster_reload_enable,
	output logic                          global_release_flag,
	output logic                          global_event_status,
	output logic                          busmaster_event_status,
	output amev_evt_t                     evt
);

	logic [7:0]               sci_source_enable_2_q;
	logic                     fw_rel_q;
	logic                     standby_q;
	logic [AMEV_NUM_EDGE-1:0] edge_sts_q;
	logic                     smi_en_q;
	logic                     tmr_run_q;
	logic                     fw_os_q;
	logic                     global_release_flag_q;
	logic                     global_event_status_q;
	logic                     busmaster_event_status_q;
	logic [AMEV_NUM_EDGE-1:0] sync1_q;
	logic [AMEV_NUM_EDGE-1:0] sync2_q;
	logic [AMEV_NUM_EDGE-1:0] prev_q;
	logic [7:0]               rdata_q;
	amev_evt_t                evt_q;
	logic                     wr_en2;
	logic                     wr_sts;
	logic                     wr_en;
	logic                     wr_ctl;
	logic                     fw_os_set;
	logic                     bm_set;

	assign wr_en2    = io_req.wr && io_req.addr == AMEV_OFF_SCI_SOURCE_ENABLE_2;
	assign wr_sts    = io_req.wr && io_req.addr == AMEV_OFF_STATUS;
	assign wr_en     = io_req.wr && io_req.addr == AMEV_OFF_ENABLE;
	assign wr_ctl    = io_req.wr && io_req.addr == AMEV_OFF_CONTROL;
	assign fw_os_set = wr_ctl && io_req.wdata[AMEV_CTL_FW_OS];
	assign bm_set    = wr_ctl && io_req.wdata[AMEV_CTL_BM];

	// source enables
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			sci_source_enable_2_q <= AMEV_RST_SCI_SOURCE_ENABLE_2;
		end else if (wr_en2) begin
			sci_source_enable_2_q <= {2'h0, io_req.wdata[AMEV_NUM_SRC-1:0]};
		end
	end

	// misc enable
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			smi_en_q  <= AMEV_RST_ENABLE[AMEV_EN_SMI];
			tmr_run_q <= AMEV_RST_ENABLE[AMEV_EN_TMR];
		end else if (wr_en) begin
			smi_en_q  <= io_req.wdata[AMEV_EN_SMI];
			tmr_run_q <= io_req.wdata[AMEV_EN_TMR];
		end
	end

	// global release flag and firmware release status
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			global_release_flag_q <= 1'b0;
			fw_rel_q  <= AMEV_RST_STATUS[AMEV_STS_FW_REL];
		end else begin
			if (global_release_set) begin
				global_release_flag_q <= 1'b1;
			end else if (wr_sts && io_req.wdata[AMEV_STS_FW_REL]) begin
				global_release_flag_q <= 1'b0;
			end
			if (global_release_set ||
			    (global_release_flag_q && !(wr_sts && io_req.wdata[AMEV_STS_FW_REL]))) begin
				fw_rel_q <= 1'b1;
			end else if (wr_sts && io_req.wdata[AMEV_STS_FW_REL]) begin
				fw_rel_q <= 1'b0;
			end
		end
	end

	// standby power-on status
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			standby_q <= AMEV_RST_STATUS[AMEV_STS_STANDBY];
		end else if (wr_sts && io_req.wdata[AMEV_STS_STANDBY]) begin
			standby_q <= 1'b0;
		end
	end

	// edge interrupt inputs
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			sync1_q <= '0;
			sync2_q <= '0;
			prev_q  <= '0;
		end else begin
			sync1_q <= edge_irq_pin;
			sync2_q <= sync1_q;
			prev_q  <= sync2_q;
		end
	end

	for (genvar i = 0; i < AMEV_NUM_EDGE; i++) begin : g_edge
		always_ff @(posedge clk or negedge rstn) begin
			if (!rstn) begin
				edge_sts_q[i] <= AMEV_RST_STATUS[AMEV_STS_EDGE_LO+i];
			end else if (sync2_q[i] != prev_q[i]) begin
				edge_sts_q[i] <= 1'b1;
			end else if (wr_sts && io_req.wdata[AMEV_STS_EDGE_LO+i]) begin
				edge_sts_q[i] <= 1'b0;
			end
		end
	end

	// control: firmware-to-os release and busmaster trigger
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			fw_os_q   <= AMEV_RST_CONTROL[AMEV_CTL_FW_OS];
			global_event_status_q <= 1'b0;
			busmaster_event_status_q  <= 1'b0;
		end else begin
			if (fw_os_set) begin
				fw_os_q   <= 1'b1;
				global_event_status_q <= 1'b1;
			end else if (global_event_status_clr) begin
				fw_os_q   <= 1'b0;
				global_event_status_q <= 1'b0;
			end
			if (bm_set) begin
				busmaster_event_status_q <= 1'b1;
			end else if (busmaster_event_status_clr) begin
				busmaster_event_status_q <= 1'b0;
			end
		end
	end

	// event outputs
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			evt_q <= '0;
		end else begin
			evt_q.group_sci    <= |(src_irq_status & sci_source_enable_2_q[AMEV_NUM_SRC-1:0]);
			evt_q.smi          <= global_release_flag_q && smi_en_q;
			evt_q.sci          <= (fw_os_set && global_event_enable) ||
			                      (bm_set && busmaster_reload_enable);
			evt_q.pm_timer_run <= tmr_run_q;
		end
	end

	// read data
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			rdata_q <= 8'h00;
		end else if (io_req.rd) begin
			unique case (io_req.addr)
				AMEV_OFF_SCI_SOURCE_ENABLE_2: rdata_q <= sci_source_enable_2_q;
				AMEV_OFF_STATUS:  rdata_q <= {3'h0, edge_sts_q, standby_q, fw_rel_q};
				AMEV_OFF_ENABLE:  rdata_q <= {6'h00, tmr_run_q, smi_en_q};
				AMEV_OFF_CONTROL: rdata_q <= {7'h00, fw_os_q};
				default:          rdata_q <= 8'h00;
			endcase
		end
	end

	assign io_rdata               = rdata_q;
	assign evt                    = evt_q;
	assign global_release_flag    = global_release_flag_q;
	assign global_event_status    = global_event_status_q;
	assign busmaster_event_status = busmaster_event_status_q;

endmodule

// *** hw/amev_pkg.sv ***
package amev_pkg;

	localparam logic [2:0] AMEV_OFF_SCI_SOURCE_ENABLE_2   = 3'h3;
	localparam logic [2:0] AMEV_OFF_STATUS    = 3'h4;
	localparam logic [2:0] AMEV_OFF_ENABLE    = 3'h6;
	localparam logic [2:0] AMEV_OFF_CONTROL   = 3'h7;

	localparam logic [7:0] AMEV_RST_SCI_SOURCE_ENABLE_2   = 8'h00;
	localparam logic [7:0] AMEV_RST_STATUS    = 8'h02;
	localparam logic [7:0] AMEV_RST_ENABLE    = 8'h00;
	localparam logic [7:0] AMEV_RST_CONTROL   = 8'h00;

	localparam int AMEV_NUM_SRC  = 6;
	localparam int AMEV_NUM_EDGE = 3;

	localparam int AMEV_STS_FW_REL   = 0;
	localparam int AMEV_STS_STANDBY  = 1;
	localparam int AMEV_STS_EDGE_LO  = 2;
	localparam int AMEV_EN_SMI       = 0;
	localparam int AMEV_EN_TMR       = 1;
	localparam int AMEV_CTL_FW_OS    = 0;
	localparam int AMEV_CTL_BM       = 1;

	typedef struct packed {
		logic       rd;
		logic       wr;
		logic [2:0] addr;
		logic [7:0] wdata;
	} amev_io_req_t;

	typedef struct packed {
		logic       smi;
		logic       sci;
		logic       group_sci;
		logic       pm_timer_run;
	} amev_evt_t;

endpackage

// *** verif/amev_checker.sv ***
`timescale 1ns/1ps
module amev_checker
	import amev_pkg::*;
(
	input wire logic         clk,
	input wire logic         rstn,
	input wire amev_io_req_t io_req,
	input wire logic [7:0]   io_rdata,
	input wire logic [5:0]   src_irq_status,
	input wire logic         global_release_set,
	input wire logic         global_event_enable,
	input wire logic         busmaster_reload_enable,
	input wire logic         global_release_flag,
	input wire logic         global_event_status,
	input wire logic         busmaster_event_status,
	input wire amev_evt_t    evt
);
	default clocking @(posedge clk); endclocking
	default disable iff (!rstn);
	wire w4 = io_req.wr && io_req.addr == 3'h4;
	wire w6 = io_req.wr && io_req.addr == 3'h6;
	wire w7 = io_req.wr && io_req.addr == 3'h7;
	AST_GRP: assert property (evt.group_sci |-> $past(|src_irq_status))
		else $error("group sci without source");
	AST_EN2: assert property ($past(io_req.rd && io_req.addr == 3'h3) |-> !io_rdata[7:6])
		else $error("enable2 top bits set");
	AST_STS: assert property ($past(io_req.rd && io_req.addr == 3'h4) |-> !io_rdata[7:5])
		else $error("status top bits set");
	AST_CTL: assert property ($past(io_req.rd && io_req.addr[2:1] == 2'h3) |-> !io_rdata[7:2])
		else $error("enable or control top bits set");
	AST_REL: assert property (global_release_set |=> global_release_flag)
		else $error("release flag not set");
	AST_SMI: assert property (evt.smi |-> $past(global_release_flag))
		else $error("smi without release");
	AST_RCLR: assert property (w4 && io_req.wdata[0] && !global_release_set |=> !global_release_flag)
		else $error("release flag not cleared");
	AST_TMR: assert property (w6 |-> ##2 evt.pm_timer_run == $past(io_req.wdata[1], 2))
		else $error("timer run wrong");
	AST_FW: assert property (w7 && io_req.wdata[0] && global_event_enable |=> evt.sci && global_event_status)
		else $error("release sci missing");
	AST_BM: assert property (w7 && io_req.wdata[1] |=> busmaster_event_status)
		else $error("busmaster status missing");
	AST_BMS: assert property (w7 && io_req.wdata[1] && busmaster_reload_enable |=> evt.sci)
		else $error("busmaster sci missing");
endmodule
bind amev_block amev_checker u_chk (.*);

// *** verif/amev_host.sv ***
`timescale 1ns/1ps
module amev_host
	import amev_pkg::*;
(
	input wire logic [7:0] io_rdata,
	input wire logic       clk,
	output amev_io_req_t   io_req
);
	initial io_req = '0;
	task automatic wr(input logic [2:0] a, input logic [7:0] d);
		logic [7:0] m;
		m = (a == 3'h3) ? 8'h3F : (a == 3'h4) ? 8'h1F : 8'h03;
		@(negedge clk);
		io_req = '{1'b0, 1'b1, a, d & m};
		@(negedge clk);
		io_req = '{1'b0, 1'b0, ~a, ~io_req.wdata};
	endtask
	task automatic rd(input logic [2:0] a, output logic [7:0] d);
		@(negedge clk);
		io_req = '{1'b1, 1'b0, a, ~io_req.wdata};
		@(negedge clk);
		io_req.rd = 1'b0;
		d = io_rdata;
	endtask
endmodule

// *** verif/tb.sv ***
`timescale 1ns/1ps
module tb;
	import amev_pkg::*;
	logic         clk, rstn, rel, gclr, bclr, gen, rld, flag, gsts, bsts;
	logic [5:0]   src;
	logic [2:0]   pin;
	logic [7:0]   io_rdata;
	int           errors, samples_checked;
	amev_io_req_t io_req;
	amev_evt_t    evt;
	amev_host u_host (.clk(clk), .io_rdata(io_rdata), .io_req(io_req));
	amev_block u_dut (.clk(clk), .rstn(rstn), .io_req(io_req), .io_rdata(io_rdata),
		.src_irq_status(src), .edge_irq_pin(pin), .global_release_set(rel),
		.global_event_status_clr(gclr), .busmaster_event_status_clr(bclr),
		.global_event_enable(gen), .busmaster_reload_enable(rld),
		.global_release_flag(flag), .global_event_status(gsts),
		.busmaster_event_status(bsts), .evt(evt));
	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end
	task automatic chk(string n, logic [7:0] e, logic [7:0] g);
		samples_checked++;
		if (g !== e) begin
			errors++;
			$display("FAIL %s exp %h got %h", n, e, g);
		end
	endtask
	task automatic rdc(logic [2:0] a, logic [7:0] e);
		logic [7:0] d;
		u_host.rd(a, d);
		chk("reg", e, d);
	endtask
	task automatic stop_test();
		$display("checks %0d mismatches %0d", samples_checked, errors);
		if (errors == 0 && samples_checked > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	task automatic t_reset();
		rdc(3'h3, 8'h00);
		rdc(3'h4, 8'h02);
		rdc(3'h6, 8'h00);
		rdc(3'h7, 8'h00);
		rdc(3'h5, 8'h00);
		u_host.wr(3'h4, 8'h02);
		rdc(3'h4, 8'h00);
		$display("reset test done");
	endtask
	task automatic t_group();
		for (int i = 0; i < 6; i++) begin
			u_host.wr(3'h3, 8'h01 << i);
			src = ~(6'h01 << i);
			repeat (2) @(negedge clk);
			chk("grp_off", 8'h00, {7'h00, evt.group_sci});
			src = 6'h01 << i;
			repeat (2) @(negedge clk);
			chk("grp_on", 8'h01, {7'h00, evt.group_sci});
		end
		rdc(3'h3, 8'h20);
		for (int j = 0; j < 6; j++) begin
			pin[j % 3] = ~pin[j % 3];
			repeat (5) @(negedge clk);
			rdc(3'h4, 8'h04 << (j % 3));
			u_host.wr(3'h4, 8'h04 << (j % 3));
			rdc(3'h4, 8'h00);
		end
		$display("group and edge test done");
	endtask
	task automatic t_events();
		u_host.wr(3'h6, 8'h03);
		rel = 1'b1;
		@(negedge clk);
		rel = 1'b0;
		repeat (2) @(negedge clk);
		chk("smi", 8'h03, {6'h00, evt.smi, flag});
		chk("tmr", 8'h01, {7'h00, evt.pm_timer_run});
		rdc(3'h4, 8'h01);
		u_host.wr(3'h4, 8'h01);
		@(negedge clk);
		chk("rel_clr", 8'h00, {6'h00, evt.smi, flag});
		rdc(3'h4, 8'h00);
		u_host.wr(3'h6, 8'h00);
		@(negedge clk);
		chk("tmr_off", 8'h00, {7'h00, evt.pm_timer_run});
		{gen, rld} = 2'h3;
		u_host.wr(3'h7, 8'h01);
		chk("sci", 8'h03, {6'h00, evt.sci, gsts});
		rdc(3'h7, 8'h01);
		gclr = 1'b1;
		@(negedge clk);
		gclr = 1'b0;
		rdc(3'h7, 8'h00);
		u_host.wr(3'h7, 8'h02);
		chk("bm", 8'h03, {6'h00, evt.sci, bsts});
		bclr = 1'b1;
		@(negedge clk);
		bclr = 1'b0;
		@(negedge clk);
		chk("bm_clr", 8'h00, {6'h00, gsts, bsts});
		$display("event test done");
	endtask
	initial begin
		{rstn, rel, gclr, bclr, gen, rld, src, pin} = '0;
		repeat (6) @(negedge clk);
		rstn = 1'b1;
		t_reset();
		t_group();
		t_events();
		stop_test();
	end
	initial begin
		#100000;
		errors++;
		stop_test();
	end
endmodule
